// File: adcis_pkg.sv
// Purpose: Shared constants and types for the converter control block
// Assumes: System clock 250 MHz
// Notes: Conversion timing is modelled by cycle counts
package adcis_pkg;
  localparam logic [6:0] ADCIS_DEV_ADDR = 7'h14;
  localparam logic [6:0] ADCIS_GLOBAL_ADDR = 7'h77;
  localparam int ADCIS_CLK_MHZ = 250;
  localparam int ADCIS_POR_US = 500;
  localparam int ADCIS_POR_CYC = ADCIS_POR_US * ADCIS_CLK_MHZ;
  localparam int ADCIS_CONV60_US = 16600;
  localparam int ADCIS_CONV30_US = 33200;
  localparam int ADCIS_CONV60_CYC = ADCIS_CONV60_US * ADCIS_CLK_MHZ;
  localparam int ADCIS_CONV30_CYC = ADCIS_CONV30_US * ADCIS_CLK_MHZ;
  localparam int ADCIS_CAL_CYC = 16;
  localparam logic ADCIS_RATE_RST = 1'b0;
  localparam logic [15:0] ADCIS_CODE_MAX = 16'hFFFF;
  localparam logic [15:0] ADCIS_CODE_MIN = 16'h0000;
  typedef enum logic [1:0] {ADCIS_CONV, ADCIS_SLEEP, ADCIS_IO} adcis_mode_t;
  typedef struct packed {
    logic signed [17:0] value;
    logic over;
    logic under;
  } adcis_sample_t;
endpackage

// File: adcis_top.sv
// Purpose: Conversion state machine with fixed-address two-wire slave
// Assumes: SCL clocks the link side; SCL and SDA are slow against clk_sys
// Notes: Analog modulator replaced by a sample input taken at conversion end
`timescale 1ns/10ps
module adcis_top
  import adcis_pkg::*;
#(
  parameter int POR_CYC = ADCIS_POR_CYC,
  parameter int CONV60_CYC = ADCIS_CONV60_CYC,
  parameter int CONV30_CYC = ADCIS_CONV30_CYC
) (
  // System
  input wire logic clk_sys,
  input wire logic rst,
  // Link
  input wire logic scl_clk,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Modulator sample and offset
  input wire adcis_sample_t sample_i,
  input wire logic signed [17:0] offset_i,
  // Status
  output adcis_mode_t mode_o,
  output logic rate_30_o
);

  // Link side state, on scl_clk
  typedef enum {LK_IDLE, LK_ADDR, LK_AACK, LK_RD, LK_RACK, LK_WR, LK_WACK, LK_IGN} adcis_lk_t;

  // START/STOP detection: sampled on system clock through synchronisers
  logic [1:0] scl_sy_r, sda_sy_r;
  logic [1:0] scl_sy_nxt, sda_sy_nxt;
  logic scl_d_r, sda_d_r, scl_d_nxt, sda_d_nxt;
  logic start_ev, stop_ev;

  always_comb begin
    scl_sy_nxt = {scl_sy_r[0], scl_clk};
    sda_sy_nxt = {sda_sy_r[0], sda_i};
    scl_d_nxt = scl_sy_r[1];
    sda_d_nxt = sda_sy_r[1];
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      scl_sy_r <= 2'h3;
      sda_sy_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_sy_r <= scl_sy_nxt;
      sda_sy_r <= sda_sy_nxt;
      scl_d_r <= scl_d_nxt;
      sda_d_r <= sda_d_nxt;
    end
  end

  // Master owns these conditions; device only watches
  assign start_ev = scl_d_r && scl_sy_r[1] && sda_d_r && !sda_sy_r[1];
  assign stop_ev = scl_d_r && scl_sy_r[1] && !sda_d_r && sda_sy_r[1];

  // Start crossing into link domain via toggle; the stop toggle has no link-side user
  logic start_tg_r, start_tg_nxt, stop_tg_r, stop_tg_nxt;
  always_comb begin
    start_tg_nxt = start_tg_r ^ start_ev;
    stop_tg_nxt = stop_tg_r ^ stop_ev;
  end

  // Conversion state and POR
  adcis_mode_t mode_r, mode_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic por_r, por_nxt;
  logic rate_r, rate_nxt;
  logic rate_cur_r, rate_cur_nxt;
  logic [15:0] result_r, result_nxt;
  logic ready_r, ready_nxt;

  // Link-to-system events via toggles
  logic [2:0] sel_sy_r, done_sy_r, wr_sy_r;
  logic [2:0] sel_sy_nxt, done_sy_nxt, wr_sy_nxt;
  logic sel_tg_l, done_tg_l, wr_tg_l, wr_bit_l;
  logic valid_r, valid_nxt;
  logic pend_r, pend_nxt;
  logic pend_rate_r, pend_rate_nxt;
  logic sel_ev, done_ev, wr_ev;

  always_comb begin
    sel_sy_nxt = {sel_sy_r[1:0], sel_tg_l};
    done_sy_nxt = {done_sy_r[1:0], done_tg_l};
    wr_sy_nxt = {wr_sy_r[1:0], wr_tg_l};
  end
  assign sel_ev = sel_sy_r[2] ^ sel_sy_r[1];
  assign done_ev = done_sy_r[2] ^ done_sy_r[1];
  assign wr_ev = wr_sy_r[2] ^ wr_sy_r[1];

  // Saturating code from sample, offset-corrected only when cal is set (30 Hz)
  function automatic logic [15:0] adcis_sat(input adcis_sample_t s, input logic signed [17:0] off, input logic cal);
    logic signed [18:0] v;
    v = 19'(s.value) - (cal ? 19'(off) : 19'sh0);
    if (s.under || v < 0) adcis_sat = ADCIS_CODE_MIN;
    else if (s.over || v > 19'sh0FFFF) adcis_sat = ADCIS_CODE_MAX;
    else adcis_sat = v[15:0];
  endfunction

  always_comb begin
    mode_nxt = mode_r;
    cnt_nxt = cnt_r;
    por_nxt = por_r;
    rate_nxt = rate_r;
    rate_cur_nxt = rate_cur_r;
    result_nxt = result_r;
    ready_nxt = ready_r;
    valid_nxt = valid_r;
    pend_nxt = pend_r;
    pend_rate_nxt = pend_rate_r;
    if (wr_ev) begin
      pend_nxt = 1'b1;
      pend_rate_nxt = wr_bit_l;
    end
    if (por_r) begin
      if (cnt_r >= 32'(POR_CYC - 1)) begin
        por_nxt = 1'b0;
        cnt_nxt = 32'h0;
        mode_nxt = ADCIS_CONV;
        rate_cur_nxt = rate_r;
      end else begin
        cnt_nxt = cnt_r + 32'h1;
      end
    end else begin
      case (mode_r)
        ADCIS_CONV: begin
          // 30 Hz period includes calibration time; sequence unchanged
          if (cnt_r >= 32'(rate_cur_r ? CONV30_CYC + ADCIS_CAL_CYC - 1 : CONV60_CYC - 1)) begin
            result_nxt = adcis_sat(sample_i, offset_i, rate_cur_r);
            ready_nxt = 1'b1;
            mode_nxt = ADCIS_SLEEP;
            cnt_nxt = 32'h0;
          end else begin
            cnt_nxt = cnt_r + 32'h1;
          end
        end
        ADCIS_SLEEP: begin
          if (sel_ev) begin
            mode_nxt = ADCIS_IO;
            valid_nxt = 1'b1;
          end
        end
        ADCIS_IO: begin
          if (sel_ev) valid_nxt = 1'b1;
          if (done_ev || (stop_ev && valid_r)) begin
            if (pend_r || wr_ev) begin
              rate_nxt = wr_ev ? wr_bit_l : pend_rate_r;
            end
            rate_cur_nxt = (pend_r || wr_ev) ? (wr_ev ? wr_bit_l : pend_rate_r) : rate_r;
            pend_nxt = 1'b0;
            valid_nxt = 1'b0;
            ready_nxt = 1'b0;
            mode_nxt = ADCIS_CONV;
            cnt_nxt = 32'h0;
          end
        end
        default: mode_nxt = ADCIS_CONV;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_r <= ADCIS_CONV;
      cnt_r <= 32'h0;
      por_r <= 1'b1;
      rate_r <= ADCIS_RATE_RST;
      rate_cur_r <= ADCIS_RATE_RST;
      result_r <= 16'h0000;
      ready_r <= 1'b0;
      valid_r <= 1'b0;
      pend_r <= 1'b0;
      pend_rate_r <= 1'b0;
      sel_sy_r <= 3'h0;
      done_sy_r <= 3'h0;
      wr_sy_r <= 3'h0;
      start_tg_r <= 1'b0;
      stop_tg_r <= 1'b0;
      mode_o <= ADCIS_CONV;
      rate_30_o <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      cnt_r <= cnt_nxt;
      por_r <= por_nxt;
      rate_r <= rate_nxt;
      rate_cur_r <= rate_cur_nxt;
      result_r <= result_nxt;
      ready_r <= ready_nxt;
      valid_r <= valid_nxt;
      pend_r <= pend_nxt;
      pend_rate_r <= pend_rate_nxt;
      sel_sy_r <= sel_sy_nxt;
      done_sy_r <= done_sy_nxt;
      wr_sy_r <= wr_sy_nxt;
      start_tg_r <= start_tg_nxt;
      stop_tg_r <= stop_tg_nxt;
      mode_o <= mode_nxt;
      rate_30_o <= rate_nxt;
    end
  end

  // Link domain; ready and result are static while sleeping, so a level sync suffices
  logic [1:0] rdy_l_r, start_l_r, hist_r, hist_nxt;
  logic start_l_d;
  adcis_lk_t lk_r, lk_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [15:0] out_r, out_nxt;
  logic rw_r, rw_nxt;
  logic wcnt_r, wcnt_nxt;
  logic sel_tg_r, sel_tg_nxt, done_tg_r, done_tg_nxt, wr_tg_r, wr_tg_nxt, wbit_r, wbit_nxt;
  logic pull_nxt;
  logic restart;
  logic addr_hit;

  assign sel_tg_l = sel_tg_r;
  assign done_tg_l = done_tg_r;
  assign wr_tg_l = wr_tg_r;
  assign wr_bit_l = wbit_r;

  // START reaches link at third address rise; first two bits kept in hist_r
  assign restart = start_l_r[1] ^ start_l_d;
  assign addr_hit = (sh_r[6:0] == ADCIS_DEV_ADDR)
    || (sh_r[6:0] == ADCIS_GLOBAL_ADDR && !sda_i);

  always_ff @(posedge scl_clk) begin
    if (rst) begin
      rdy_l_r <= 2'h0;
      start_l_r <= 2'h0;
      start_l_d <= 1'b0;
    end else begin
      rdy_l_r <= {rdy_l_r[0], ready_r};
      start_l_r <= {start_l_r[0], start_tg_r};
      start_l_d <= start_l_r[1];
    end
  end

  // Rising edge: sample SDA and advance the byte state
  always_comb begin
    lk_nxt = lk_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    rw_nxt = rw_r;
    wcnt_nxt = wcnt_r;
    sel_tg_nxt = sel_tg_r;
    done_tg_nxt = done_tg_r;
    wr_tg_nxt = wr_tg_r;
    wbit_nxt = wbit_r;
    hist_nxt = {hist_r[0], sda_i};
    if (restart) begin
      lk_nxt = LK_ADDR;
      bit_nxt = 4'h3;
      sh_nxt = {5'h00, hist_r, sda_i};
    end else begin
      case (lk_r)
        LK_ADDR: begin
          sh_nxt = {sh_r[6:0], sda_i};
          bit_nxt = bit_r + 4'h1;
          if (bit_r == 4'h7) begin
            rw_nxt = sda_i;
            if (addr_hit && rdy_l_r[1]) begin
              lk_nxt = LK_AACK;
              sel_tg_nxt = ~sel_tg_r;
            end else begin
              lk_nxt = LK_IGN;
            end
          end
        end
        LK_AACK: begin
          bit_nxt = 4'h0;
          wcnt_nxt = 1'b0;
          lk_nxt = rw_r ? LK_RD : LK_WR;
        end
        LK_RD: begin
          bit_nxt = bit_r + 4'h1;
          if (bit_r == 4'h7 || bit_r == 4'hF) lk_nxt = LK_RACK;
        end
        LK_RACK: begin
          if (bit_r == 4'h0) begin
            lk_nxt = LK_IGN;
            done_tg_nxt = ~done_tg_r;
          end else begin
            lk_nxt = LK_RD;
          end
        end
        LK_WR: begin
          sh_nxt = {sh_r[6:0], sda_i};
          bit_nxt = bit_r + 4'h1;
          if (bit_r == 4'h7) begin
            lk_nxt = LK_WACK;
            if (!wcnt_r) begin
              wbit_nxt = sda_i;
              wr_tg_nxt = ~wr_tg_r;
            end
          end
        end
        LK_WACK: begin
          bit_nxt = 4'h0;
          wcnt_nxt = 1'b1;
          lk_nxt = LK_WR;
        end
        default: lk_nxt = lk_r;
      endcase
    end
  end

  always_ff @(posedge scl_clk) begin
    if (rst) begin
      lk_r <= LK_IDLE;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      rw_r <= 1'b0;
      wcnt_r <= 1'b0;
      sel_tg_r <= 1'b0;
      done_tg_r <= 1'b0;
      wr_tg_r <= 1'b0;
      wbit_r <= 1'b0;
      hist_r <= 2'h0;
    end else begin
      lk_r <= lk_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      rw_r <= rw_nxt;
      wcnt_r <= wcnt_nxt;
      sel_tg_r <= sel_tg_nxt;
      done_tg_r <= done_tg_nxt;
      wr_tg_r <= wr_tg_nxt;
      wbit_r <= wbit_nxt;
      hist_r <= hist_nxt;
    end
  end

  // Falling edge: drive SDA low only, never high
  always_comb begin
    out_nxt = out_r;
    pull_nxt = 1'b0;
    case (lk_r)
      LK_AACK: begin
        pull_nxt = 1'b1;
        out_nxt = result_r;
      end
      LK_RD: begin
        pull_nxt = !out_r[15];
        out_nxt = {out_r[14:0], 1'b0};
      end
      LK_WACK: pull_nxt = !wcnt_r;
      default: pull_nxt = 1'b0;
    endcase
  end

  always_ff @(negedge scl_clk) begin
    if (rst) begin
      out_r <= 16'h0000;
      sda_oe <= 1'b0;
    end else begin
      out_r <= out_nxt;
      sda_oe <= pull_nxt;
    end
  end

  // Open drain: output value is always low
  always_ff @(posedge clk_sys) begin
    sda_o <= 1'b0;
  end

endmodule

// File: adcis_monitor.sv
// Purpose: Port checker for the converter control block
// Assumes: SCL and SDA are slow against clk_sys
// Notes: Attached by the bind at the foot
`timescale 1ns/10ps
module adcis_monitor
  import adcis_pkg::*;
#(
  parameter int POR_CYC = 50,
  parameter int CONV60_CYC = 200,
  parameter int CONV30_CYC = 400
) (
  // System
  input wire logic clk_sys,
  input wire logic rst,
  // Link and status
  input wire logic scl_clk,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire adcis_mode_t mode_o,
  input wire logic rate_30_o
);
  int cnv_r, cnv_nxt, idl_r, idl_nxt;
  always_comb begin
    cnv_nxt = (mode_o == ADCIS_CONV) ? cnv_r + 1 : 0;
    idl_nxt = (scl_clk && sda_i) ? idl_r + 1 : 0;
  end
  always_ff @(posedge clk_sys) begin
    cnv_r <= rst ? 0 : cnv_nxt;
    idl_r <= rst ? 0 : idl_nxt;
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  sequence stop_in_io;
    mode_o == ADCIS_IO && scl_clk && $rose(sda_i);
  endsequence
  sequence conv_end;
    $past(mode_o) == ADCIS_CONV && mode_o == ADCIS_SLEEP;
  endsequence
  a_drain_only: assert property (!sda_o) else $error("sda_o not low");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_clk) else $error("sda_oe moved, SCL high");
  a_mode_order: assert property ($changed(mode_o) |-> (mode_o == ADCIS_SLEEP && $past(mode_o) == ADCIS_CONV)
    || (mode_o == ADCIS_IO && $past(mode_o) == ADCIS_SLEEP) || (mode_o == ADCIS_CONV && $past(mode_o) == ADCIS_IO))
    else $error("mode step out of order");
  a_quiet_conv: assert property (mode_o == ADCIS_CONV |-> !sda_oe) else $error("SDA pulled while converting");
  // Slack of one cycle for where the count is started
  a_conv_length: assert property (conv_end |-> cnv_r >= (rate_30_o ? CONV30_CYC : CONV60_CYC) - 1
    && cnv_r <= POR_CYC + CONV30_CYC + ADCIS_CAL_CYC + 8) else $error("conversion length off");
  a_rate_at_start: assert property ($changed(rate_30_o) |-> mode_o == ADCIS_CONV && cnv_r < 4)
    else $error("rate moved outside conversion start");
  a_stop_converts: assert property (stop_in_io |-> ##[1:8] mode_o == ADCIS_CONV)
    else $error("no conversion after STOP");
  a_sleep_holds: assert property (mode_o == ADCIS_SLEEP && idl_r > 20 |=> mode_o == ADCIS_SLEEP)
    else $error("left sleep on idle bus");
endmodule
bind adcis_top adcis_monitor #(.POR_CYC(POR_CYC), .CONV60_CYC(CONV60_CYC), .CONV30_CYC(CONV30_CYC)) u_mon (
  .clk_sys(clk_sys), .rst(rst), .scl_clk(scl_clk), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .mode_o(mode_o), .rate_30_o(rate_30_o));

// File: adcis_master.sv
// Purpose: Two-wire bus master model
// Assumes: Pull-up on SDA, SCL idles high
// Notes: 64 ns bit time, SDA moved mid SCL low
`timescale 1ns/10ps
module adcis_master (
  // Bus
  output logic scl_clk,
  output logic sda_pull,
  input wire logic sda_i
);
  initial begin
    scl_clk = 1'h1;
    sda_pull = 1'h0;
  end
  task automatic bit_io(input logic b, output logic s);
    sda_pull = !b;
    #16 scl_clk = 1'h1;
    #8 s = sda_i;
    #24 scl_clk = 1'h0;
    #16;
  endtask
  // Offset of 1 ns keeps SCL edges off the system clock edges when start follows a clock edge; a repeated start puts them back on
  task automatic start();
    #1 sda_pull = 1'h0;
    #16 scl_clk = 1'h1;
    #16 sda_pull = 1'h1;
    #32 scl_clk = 1'h0;
  endtask
  task automatic stop();
    sda_pull = 1'h1;
    #16 scl_clk = 1'h1;
    #16 sda_pull = 1'h0;
    #32;
  endtask
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(mack, ack);
    ack = !ack;
  endtask
endmodule

// File: adcis_top_tb.sv
// Purpose: Self-checking bench for adcis_top
// Assumes: Short conversion counts
// Notes: Corner sample values first, then random samples from a fixed seed
`timescale 1ns/10ps
module adcis_top_tb;
  import adcis_pkg::*;
  logic clk_sys = 1'h0, rst = 1'h1, sda_o, sda_oe, rate_30_o, scl_clk, sda_pull, ack, rate_x = 1'h0;
  wire logic sda;
  adcis_sample_t sample_i = '0;
  logic signed [17:0] offset_i = '0;
  logic signed [17:0] corner [4] = '{18'sh00000, 18'sh0FFFF, 18'sh10000, 18'sh3FFFF};
  adcis_mode_t mode_o;
  logic [7:0] q, hi, lo;
  logic [6:0] a;
  logic [15:0] ex;
  logic [31:0] seed = 32'h17, rv;
  int fails = 0, checked = 0, k;
  always #2 clk_sys = !clk_sys;
  assign sda = !((sda_oe && !sda_o) || sda_pull);
  adcis_master m (.scl_clk(scl_clk), .sda_pull(sda_pull), .sda_i(sda));
  adcis_top #(.POR_CYC(50), .CONV60_CYC(200), .CONV30_CYC(400)) dut (.clk_sys(clk_sys), .rst(rst),
    .scl_clk(scl_clk), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .sample_i(sample_i),
    .offset_i(offset_i), .mode_o(mode_o), .rate_30_o(rate_30_o));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] code(adcis_sample_t s, logic signed [17:0] o, logic r30);
    logic signed [19:0] v;
    v = s.value - (r30 ? o : 18'sh0);
    if (s.under || v < 0) return ADCIS_CODE_MIN;
    if (s.over || v > 20'sh0FFFF) return ADCIS_CODE_MAX;
    return v[15:0];
  endfunction
  task automatic chk(string what, logic [15:0] e, logic [15:0] g);
    checked++;
    if (e !== g) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic new_sample(int n);
    logic [31:0] r;
    r = rnd();
    @(posedge clk_sys);
    sample_i.value <= (n < 4) ? corner[n] : r[17:0];
    sample_i.over <= r[31:28] == 4'h0;
    sample_i.under <= r[27:24] == 4'h0 && r[31:28] != 4'h0;
    offset_i <= {{7{r[23]}}, r[23:13]};
  endtask
  task automatic wait_sleep();
    int n;
    n = 0;
    while (mode_o !== ADCIS_SLEEP && n < 2000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 2000) begin
      fails++;
      give_verdict();
    end
  endtask
  initial begin
    // One SCL fall inside reset clears sda_oe and out_r on the link side
    fork
      m.bit_io(1'h1, ack);
    join_none
    repeat (16) @(posedge clk_sys);
    rst <= 1'h0;
    @(posedge clk_sys);
    #1;
    chk("mode", ADCIS_CONV, mode_o);
    chk("rate", 1'h0, rate_30_o);
    new_sample(0);
    m.start();
    m.xfer({ADCIS_DEV_ADDR, 1'h1}, 1'h1, q, ack);
    chk("busy ack", 1'h0, ack);
    m.stop();
    for (int i = 0; i < 12; i++) begin
      k = i % 4;
      wait_sleep();
      repeat (40) @(posedge clk_sys);
      chk("sleep", ADCIS_SLEEP, mode_o);
      ex = code(sample_i, offset_i, rate_30_o);
      rv = rnd();
      m.start();
      if (k == 1) begin
        a = (rv[6:0] == ADCIS_DEV_ADDR || rv[6:0] == ADCIS_GLOBAL_ADDR) ? rv[6:0] ^ 7'h01 : rv[6:0];
        m.xfer({a, rv[7]}, 1'h1, q, ack);
        chk("foreign ack", 1'h0, ack);
        m.stop();
        chk("still sleep", ADCIS_SLEEP, mode_o);
        m.start();
      end
      if (k >= 2) begin
        m.xfer({(i == 10) ? ADCIS_GLOBAL_ADDR : ADCIS_DEV_ADDR, 1'h0}, 1'h1, q, ack);
        chk("write ack", 1'h1, ack);
        // Test 2 forces 30 Hz so the calibration path is reached
        m.xfer(rv[15:8] | {7'h00, i == 2}, 1'h1, q, ack);
        chk("config ack", 1'h1, ack);
        rate_x = rv[8] | (i == 2);
        if (k == 2) begin
          m.xfer(rv[23:16], 1'h1, q, ack);
          chk("extra ack", 1'h0, ack);
          m.stop();
        end else m.start();
      end
      if (k != 2) begin
        m.xfer({ADCIS_DEV_ADDR, 1'h1}, 1'h1, q, ack);
        chk("read ack", 1'h1, ack);
        m.xfer(8'hFF, 1'h0, hi, ack);
        m.xfer(8'hFF, 1'h0, lo, ack);
        chk("result", ex, {hi, lo});
        chk("after read", ADCIS_CONV, mode_o);
        m.xfer(8'hFF, 1'h0, q, ack);
        chk("past bit 0", 8'hFF, q);
        m.stop();
      end
      chk("rate", rate_x, rate_30_o);
      chk("converting", ADCIS_CONV, mode_o);
      new_sample(i + 1);
      $display("test %0d kind %0d done", i, k);
    end
    give_verdict();
  end
endmodule
